//--- rtl/lpma_top.sv
`timescale 1ns/1ps
module lpma_top #(
  parameter int unsigned MEM_AW = 12
) (
  input  wire logic                         clk_i,
  input  wire logic                         resetn_i,
  input  wire logic [lpma_pkg::ADDR_W-1:0]  avs_address_i,
  input  wire logic                         avs_read_i,
  input  wire logic                         avs_write_i,
  input  wire logic [lpma_pkg::BUS_W-1:0]   avs_writedata_i,
  input  wire logic [lpma_pkg::BE_W-1:0]    avs_byteenable_i,
  output logic      [lpma_pkg::BUS_W-1:0]   avs_readdata_o,
  output logic                              avs_waitrequest_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [MEM_AW-1:0] mem_idx(
    input logic [lpma_pkg::PTR_W-1:0] p
  );
    mem_idx = p[MEM_AW-1:0];
  endfunction

  function automatic logic [lpma_pkg::PTR_W-1:0] sext(
    input logic [lpma_pkg::BYTE_W-1:0] b
  );
    sext = {{(lpma_pkg::PTR_W-lpma_pkg::BYTE_W){b[lpma_pkg::BYTE_W-1]}}, b};
  endfunction

  typedef enum {
    ST_IDLE,
    ST_ACC1,
    ST_ACC2,
    ST_DONE
  } lpma_state_t;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Only the low MEM_AW pointer bits reach the array; upper bits alias
  logic [lpma_pkg::BYTE_W-1:0] mem_q [2**MEM_AW];

  lpma_state_t                  state_q;
  lpma_state_t                  state_d;
  lpma_pkg::lpma_op_t           op_q;
  lpma_pkg::lpma_op_t           op_d;
  logic [lpma_pkg::PTR_W-1:0]   ptr_q;
  logic [lpma_pkg::PTR_W-1:0]   ptr_d;
  logic [lpma_pkg::BUS_W-1:0]   rdata_q;
  logic [lpma_pkg::BUS_W-1:0]   rdata_d;
  logic                         wait_q;
  logic                         wait_d;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire logic [lpma_pkg::IDX_W-1:0] idx_w =
    avs_address_i[lpma_pkg::IDX_LSB +: lpma_pkg::IDX_W];
  wire logic             req_w   = avs_read_i | avs_write_i;
  // Enum is two-state, so it lives in a variable, not a net
  lpma_pkg::lpma_kind_t kind_w;
  assign kind_w =
    (idx_w == lpma_pkg::IDX_PTR_LO)  ? lpma_pkg::LPMA_OP_PTR_LO  :
    (idx_w == lpma_pkg::IDX_PTR_MID) ? lpma_pkg::LPMA_OP_PTR_MID :
    (idx_w == lpma_pkg::IDX_PTR_HI)  ? lpma_pkg::LPMA_OP_PTR_HI  :
    (idx_w == lpma_pkg::IDX_ADJUST)  ? lpma_pkg::LPMA_OP_ADJUST  :
    (idx_w == lpma_pkg::IDX_PLAIN)   ? lpma_pkg::LPMA_OP_PLAIN   :
    (idx_w == lpma_pkg::IDX_WORD)    ? lpma_pkg::LPMA_OP_WORD    :
    (idx_w == lpma_pkg::IDX_AUTOINC) ? lpma_pkg::LPMA_OP_AUTOINC :
                                       lpma_pkg::LPMA_OP_NONE;
  wire logic is_word_w = (op_q.kind == lpma_pkg::LPMA_OP_WORD);
  wire logic is_mem_w  = is_word_w
                       | (op_q.kind == lpma_pkg::LPMA_OP_PLAIN)
                       | (op_q.kind == lpma_pkg::LPMA_OP_AUTOINC);
  // Word port writes need both low lanes; a lone lane is dropped
  wire logic wr_ok_w   = op_q.is_write
                       & (is_word_w ? (&op_q.be) : op_q.be[0]);
  wire logic [lpma_pkg::PTR_W-1:0] ptr_nxt_w =
    ptr_q + lpma_pkg::STEP_BYTE;
  wire logic [lpma_pkg::BYTE_W-1:0] byte0_w = mem_q[mem_idx(ptr_q)];
  wire logic [lpma_pkg::BYTE_W-1:0] byte1_w = mem_q[mem_idx(ptr_nxt_w)];
  wire logic mem_we_w  = wr_ok_w & is_mem_w
                       & ((state_q == ST_ACC1) | (state_q == ST_ACC2));
  // First byte of a word goes high, like a 16-bit load of two bytes
  wire logic [MEM_AW-1:0] mem_wa_w =
    (state_q == ST_ACC2) ? mem_idx(ptr_nxt_w) : mem_idx(ptr_q);
  wire logic [lpma_pkg::BYTE_W-1:0] mem_wd_w =
    (state_q == ST_ACC2) ? op_q.wdata[lpma_pkg::BYTE_W-1:0] :
    is_word_w ? op_q.wdata[2*lpma_pkg::BYTE_W-1:lpma_pkg::BYTE_W] :
                op_q.wdata[lpma_pkg::BYTE_W-1:0];

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    op_d    = op_q;
    ptr_d   = ptr_q;
    rdata_d = rdata_q;
    wait_d  = 1'b1;
    case (state_q)
      ST_IDLE: begin
        if (req_w) begin
          op_d.kind     = kind_w;
          op_d.is_write = avs_write_i;
          op_d.be       = avs_byteenable_i[1:0];
          op_d.wdata    = avs_writedata_i[2*lpma_pkg::BYTE_W-1:0];
          state_d       = ST_ACC1;
        end
      end
      ST_ACC1: begin
        rdata_d = lpma_pkg::RDATA_RST;
        case (op_q.kind)
          lpma_pkg::LPMA_OP_PTR_LO:
            rdata_d[7:0] = ptr_q[7:0];
          lpma_pkg::LPMA_OP_PTR_MID:
            rdata_d[7:0] = ptr_q[15:8];
          lpma_pkg::LPMA_OP_PTR_HI:
            rdata_d[7:0] = ptr_q[23:16];
          lpma_pkg::LPMA_OP_PLAIN,
          lpma_pkg::LPMA_OP_AUTOINC:
            rdata_d[7:0] = byte0_w;
          lpma_pkg::LPMA_OP_WORD:
            rdata_d[15:0] = {byte0_w, byte1_w};
          default:
            rdata_d = lpma_pkg::RDATA_RST;
        endcase
        if (!op_q.is_write) begin
          op_d.wdata = rdata_d[2*lpma_pkg::BYTE_W-1:0];
        end
        state_d = is_word_w ? ST_ACC2 : ST_DONE;
        wait_d  = is_word_w;
      end
      ST_ACC2: begin
        state_d = ST_DONE;
        wait_d  = 1'b0;
      end
      ST_DONE: begin
        // Pointer moves only at the edge that completes the access
        state_d = ST_IDLE;
        if (wr_ok_w) begin
          case (op_q.kind)
            lpma_pkg::LPMA_OP_PTR_LO:
              ptr_d[7:0] = op_q.wdata[7:0];
            lpma_pkg::LPMA_OP_PTR_MID:
              ptr_d[15:8] = op_q.wdata[7:0];
            lpma_pkg::LPMA_OP_PTR_HI:
              ptr_d[23:16] = op_q.wdata[7:0];
            lpma_pkg::LPMA_OP_ADJUST:
              ptr_d = ptr_q + sext(op_q.wdata[7:0]);
            default:
              ptr_d = ptr_q;
          endcase
        end
        if (op_q.kind == lpma_pkg::LPMA_OP_AUTOINC) begin
          ptr_d = ptr_nxt_w;
        end
        if (is_word_w && (wr_ok_w || !op_q.is_write)) begin
          ptr_d = ptr_q + lpma_pkg::STEP_WORD;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q  <= ST_IDLE;
      op_q     <= '0;
      ptr_q    <= lpma_pkg::PTR_RST;
      rdata_q  <= lpma_pkg::RDATA_RST;
      wait_q   <= 1'b1;
    end else begin
      state_q  <= state_d;
      op_q     <= op_d;
      ptr_q    <= ptr_d;
      rdata_q  <= rdata_d;
      wait_q   <= wait_d;
    end
  end

  // Array not reset; a location is undefined until first written

  always_ff @(posedge clk_i) begin
    if (mem_we_w) begin
      mem_q[mem_wa_w] <= mem_wd_w;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  wire logic done_w = (state_q == ST_DONE);

  sequence seq_done(lpma_pkg::lpma_kind_t k, logic w);
    done_w && (op_q.kind == k) && (op_q.is_write == w);
  endsequence

  sequence seq_issue(logic [lpma_pkg::IDX_W-1:0] ix);
    (state_q == ST_IDLE) && req_w && (idx_w == ix);
  endsequence

  AST_AUTO_READ: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    seq_done(lpma_pkg::LPMA_OP_AUTOINC, 1'b0) |->
      (avs_readdata_o[7:0] == mem_q[mem_idx(ptr_q)]) && !avs_waitrequest_o
      ##1 (ptr_q == $past(ptr_q) + lpma_pkg::STEP_BYTE))
    else $error("autoinc read data or step wrong");

  AST_AUTO_WRITE: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    seq_done(lpma_pkg::LPMA_OP_AUTOINC, 1'b1) ##0 op_q.be[0] |=>
      (mem_q[mem_idx($past(ptr_q))] == $past(op_q.wdata[7:0]))
      && (ptr_q == $past(ptr_q) + lpma_pkg::STEP_BYTE))
    else $error("autoinc write store or step wrong");

  AST_WORD_STEP: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    seq_done(lpma_pkg::LPMA_OP_WORD, 1'b0) |=>
      (ptr_q == $past(ptr_q) + lpma_pkg::STEP_WORD))
    else $error("word port did not advance by two");

  AST_WORD_READ: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    seq_issue(lpma_pkg::IDX_WORD) ##0 avs_read_i |->
      ##3 (!avs_waitrequest_o && avs_readdata_o[15:0] ==
           {$past(byte0_w, 3), $past(byte1_w, 3)}))
    else $error("word read bytes wrong");

  AST_PLAIN_READ: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    seq_issue(lpma_pkg::IDX_PLAIN) ##0 avs_read_i |->
      avs_waitrequest_o [*2] ##1
      (!avs_waitrequest_o && avs_readdata_o[7:0] == byte0_w)
      ##1 $stable(ptr_q))
    else $error("plain read wrong or pointer moved");

  AST_PLAIN_WRITE: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    seq_done(lpma_pkg::LPMA_OP_PLAIN, 1'b1) ##0 op_q.be[0] |=>
      $stable(ptr_q) && (mem_q[mem_idx(ptr_q)] == $past(op_q.wdata[7:0])))
    else $error("plain write wrong or pointer moved");

  AST_ADJUST: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    seq_done(lpma_pkg::LPMA_OP_ADJUST, 1'b1) ##0 op_q.be[0] |=>
      (ptr_q == $past(ptr_q) + sext($past(op_q.wdata[7:0]))))
    else $error("signed pointer adjust wrong");

  AST_WRAP: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    done_w && (op_q.kind == lpma_pkg::LPMA_OP_AUTOINC) && (&ptr_q) |=>
      (ptr_q == lpma_pkg::PTR_RST))
    else $error("pointer did not wrap to zero");

  // Fixed latency: byte ports answer after two busy cycles, word after three
  sequence seq_byte_answer;
    avs_waitrequest_o [*2] ##1 !avs_waitrequest_o;
  endsequence

  sequence seq_word_answer;
    avs_waitrequest_o [*3] ##1 !avs_waitrequest_o;
  endsequence

  AST_AUTO_TIMING: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    seq_issue(lpma_pkg::IDX_AUTOINC) |->
      seq_byte_answer ##1 (ptr_q == $past(ptr_q, 3) + lpma_pkg::STEP_BYTE))
    else $error("autoinc answer late or pointer not stepped");

  AST_WORD_TIMING: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    seq_issue(lpma_pkg::IDX_WORD) |-> seq_word_answer)
    else $error("word port answer timing wrong");

  AST_PTR_HOLD: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (state_q != ST_DONE) |=> $stable(ptr_q))
    else $error("pointer moved before the access completed");

  AST_WORD_WRITE: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    seq_done(lpma_pkg::LPMA_OP_WORD, 1'b1) ##0 (&op_q.be) |=>
      (mem_q[mem_idx($past(ptr_q))] == $past(op_q.wdata[15:8]))
      && (mem_q[mem_idx($past(ptr_nxt_w))] == $past(op_q.wdata[7:0]))
      && (ptr_q == $past(ptr_q) + lpma_pkg::STEP_WORD))
    else $error("word write bytes or step wrong");

  AST_WORD_LANE: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    seq_done(lpma_pkg::LPMA_OP_WORD, 1'b1) ##0 !(&op_q.be) |=>
      $stable(ptr_q))
    else $error("word write with one lane moved the pointer");

  AST_ANSWER_ONE: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer lasted more than one cycle");

endmodule

//--- inc/lpma_pkg.sv
// Operation
// - A read of the auto-advancing byte port returns the byte at the pointer, then the pointer steps by one.
// - A write to the auto-advancing byte port stores the byte at the pointer, then the pointer steps by one.
// - The auto-advancing byte port uses the pointer as address and always advances afterwards; the word port does not advance on a dropped write.
// - The word port sits just below the auto-advancing byte port and moves two consecutive bytes.
// - The plain byte port reads or writes the byte at the low MEM_AW pointer bits and leaves the pointer alone.
// - A byte written to the adjust register is added to the pointer as a signed value.
package lpma_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned PTR_W   = 24;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned BUS_W   = 32;
  localparam int unsigned ADDR_W  = 5;
  localparam int unsigned BE_W    = 4;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_W   = 3;

  // ----------------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PTR_LO   = 3'h0;
  localparam logic [IDX_W-1:0] IDX_PTR_MID  = 3'h1;
  localparam logic [IDX_W-1:0] IDX_PTR_HI   = 3'h2;
  localparam logic [IDX_W-1:0] IDX_ADJUST   = 3'h3;
  localparam logic [IDX_W-1:0] IDX_PLAIN    = 3'h4;
  localparam logic [IDX_W-1:0] IDX_WORD     = 3'h5;
  localparam logic [IDX_W-1:0] IDX_AUTOINC  = 3'h6;

  // ----------------------------------------------------------------------
  // Reset values and steps
  // ----------------------------------------------------------------------
  localparam logic [PTR_W-1:0]  PTR_RST    = 24'h000000;
  localparam logic [PTR_W-1:0]  STEP_BYTE  = 24'h000001;
  localparam logic [PTR_W-1:0]  STEP_WORD  = 24'h000002;
  localparam logic [BUS_W-1:0]  RDATA_RST  = 32'h00000000;
  localparam logic [BYTE_W-1:0] MEM_RST    = 8'hff;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum {
    LPMA_OP_NONE,
    LPMA_OP_PTR_LO,
    LPMA_OP_PTR_MID,
    LPMA_OP_PTR_HI,
    LPMA_OP_ADJUST,
    LPMA_OP_PLAIN,
    LPMA_OP_WORD,
    LPMA_OP_AUTOINC
  } lpma_kind_t;

  typedef struct packed {
    lpma_kind_t         kind;
    logic               is_write;
    logic [1:0]         be;
    logic [2*BYTE_W-1:0] wdata;
  } lpma_op_t;

endpackage

//--- test/lpma_tb.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic                           clk_i;
  logic                           resetn_i;
  logic [lpma_pkg::ADDR_W-1:0]    avs_address_i;
  logic                           avs_read_i;
  logic                           avs_write_i;
  logic [lpma_pkg::BUS_W-1:0]     avs_writedata_i;
  logic [lpma_pkg::BE_W-1:0]      avs_byteenable_i;
  logic [lpma_pkg::BUS_W-1:0]     avs_readdata_o;
  logic                           avs_waitrequest_o;
  logic [31:0]                    exp_q[$];
  logic [31:0]                    msk_q[$];
  string                          nm_q[$];
  logic [7:0]                     mem_m[0:4095];
  logic [23:0]                    ptr_m;
  logic [31:0]                    e;
  logic [31:0]                    m;
  int                             mismatches;
  int                             total_checks;
  integer                         seed;
  logic [3:0]                     be_m;

  lpma_top #(.MEM_AW(12)) u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Bus master and model
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Request held until waitrequest is seen low at an edge
  task automatic acc(input logic [2:0] idx, input logic rd,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= {idx, 2'b00};
    avs_read_i <= rd;
    avs_write_i <= ~rd;
    avs_writedata_i <= wd;
    avs_byteenable_i <= be_m;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 40) begin
        mismatches++;
        $display("wrong value waitrequest expected 0 seen 1");
        wrap_up();
      end
    end while (avs_waitrequest_o !== 1'b0);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  // Byte registers need lane 0, the word port needs both low lanes
  task automatic put(input logic [2:0] idx, input logic [15:0] w);
    acc(idx, 1'b0, {16'h0000, w});
    if (be_m[0]) begin
      case (idx)
        lpma_pkg::IDX_PTR_LO:  ptr_m[7:0] = w[7:0];
        lpma_pkg::IDX_PTR_MID: ptr_m[15:8] = w[7:0];
        lpma_pkg::IDX_PTR_HI:  ptr_m[23:16] = w[7:0];
        lpma_pkg::IDX_ADJUST:  ptr_m = ptr_m + {{16{w[7]}}, w[7:0]};
        lpma_pkg::IDX_PLAIN:   mem_m[ptr_m[11:0]] = w[7:0];
        lpma_pkg::IDX_AUTOINC: mem_m[ptr_m[11:0]] = w[7:0];
        default: ;
      endcase
    end
    if (idx == lpma_pkg::IDX_AUTOINC) ptr_m = ptr_m + 24'h000001;
    if (idx == lpma_pkg::IDX_WORD && be_m[1:0] == 2'b11) begin
      mem_m[ptr_m[11:0]] = w[15:8];
      mem_m[ptr_m[11:0] + 12'h001] = w[7:0];
      ptr_m = ptr_m + 24'h000002;
    end
  endtask

  task automatic get(input logic [2:0] idx, input string nm);
    m = 32'h000000ff;
    case (idx)
      lpma_pkg::IDX_PTR_LO:  e = {24'h000000, ptr_m[7:0]};
      lpma_pkg::IDX_PTR_MID: e = {24'h000000, ptr_m[15:8]};
      lpma_pkg::IDX_PTR_HI:  e = {24'h000000, ptr_m[23:16]};
      lpma_pkg::IDX_PLAIN, lpma_pkg::IDX_AUTOINC:
        e = {24'h000000, mem_m[ptr_m[11:0]]};
      lpma_pkg::IDX_WORD: begin
        e = {16'h0000, mem_m[ptr_m[11:0]], mem_m[ptr_m[11:0] + 12'h001]};
        m = 32'h0000ffff;
      end
      default: begin
        e = 32'h00000000;
        m = 32'hffffffff;
      end
    endcase
    exp_q.push_back(e);
    msk_q.push_back(m);
    nm_q.push_back(nm);
    acc(idx, 1'b1, 32'h00000000);
    if (idx == lpma_pkg::IDX_AUTOINC) ptr_m = ptr_m + 24'h000001;
    if (idx == lpma_pkg::IDX_WORD) ptr_m = ptr_m + 24'h000002;
  endtask

  task automatic set_ptr(input logic [23:0] v);
    put(lpma_pkg::IDX_PTR_LO, {8'h00, v[7:0]});
    put(lpma_pkg::IDX_PTR_MID, {8'h00, v[15:8]});
    put(lpma_pkg::IDX_PTR_HI, {8'h00, v[23:16]});
  endtask

  task automatic chk_ptr();
    get(lpma_pkg::IDX_PTR_LO, "pointer low");
    get(lpma_pkg::IDX_PTR_MID, "pointer mid");
    get(lpma_pkg::IDX_PTR_HI, "pointer high");
  endtask

  // ----------------------------------------------------------------
  // Read data watcher, oldest note first
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0 &&
        exp_q.size() > 0) begin
      total_checks++;
      if ((avs_readdata_o & msk_q[0]) !== exp_q[0]) begin
        mismatches++;
        $display("wrong value %s expected %h seen %h", nm_q[0], exp_q[0],
                 avs_readdata_o & msk_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
      void'(nm_q.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 80994;
    mismatches = 0;
    total_checks = 0;
    be_m = 4'hf;
    ptr_m = 24'h000000;
    for (int i = 0; i < 4096; i++) mem_m[i] = 8'hff;
    resetn_i = 1'b0;
    avs_address_i = '0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = '0;
    avs_byteenable_i = '0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    chk_ptr();
    get(3'h7, "unmapped read");
    get(lpma_pkg::IDX_ADJUST, "adjust read");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      set_ptr(24'($random(seed)));
      put(lpma_pkg::IDX_PLAIN, 16'($random(seed)));
      get(lpma_pkg::IDX_PLAIN, "plain byte");
      chk_ptr();
    end
    $display("test plain done");
    set_ptr(24'h00fffe);
    repeat (3) put(lpma_pkg::IDX_AUTOINC, 16'($random(seed)));
    chk_ptr();
    set_ptr(24'h00fffe);
    repeat (3) get(lpma_pkg::IDX_AUTOINC, "autoinc byte");
    chk_ptr();
    set_ptr(24'hffffff);
    put(lpma_pkg::IDX_AUTOINC, 16'h005a);
    chk_ptr();
    put(lpma_pkg::IDX_ADJUST, 16'h00ff);
    get(lpma_pkg::IDX_AUTOINC, "autoinc wrap");
    chk_ptr();
    $display("test autoinc done");
    set_ptr(24'($random(seed)));
    put(lpma_pkg::IDX_WORD, 16'($random(seed)));
    chk_ptr();
    put(lpma_pkg::IDX_ADJUST, 16'h00fe);
    get(lpma_pkg::IDX_AUTOINC, "word high byte");
    get(lpma_pkg::IDX_PLAIN, "word low byte");
    put(lpma_pkg::IDX_ADJUST, 16'h00ff);
    get(lpma_pkg::IDX_WORD, "word read");
    chk_ptr();
    put(lpma_pkg::IDX_ADJUST, 16'h00fe);
    be_m = 4'h1;
    put(lpma_pkg::IDX_WORD, 16'($random(seed)));
    be_m = 4'h0;
    put(lpma_pkg::IDX_AUTOINC, 16'($random(seed)));
    put(lpma_pkg::IDX_PTR_LO, 16'h0055);
    be_m = 4'hf;
    put(lpma_pkg::IDX_ADJUST, 16'h00ff);
    get(lpma_pkg::IDX_WORD, "word after lane drop");
    chk_ptr();
    $display("test word done");
    set_ptr(24'h000000);
    for (int i = 0; i < 6; i++) begin
      put(lpma_pkg::IDX_ADJUST, 16'($random(seed)));
      chk_ptr();
    end
    put(lpma_pkg::IDX_ADJUST, 16'h0080);
    chk_ptr();
    put(3'h7, 16'h0033);
    chk_ptr();
    $display("test adjust done");
    wrap_up();
  end
endmodule
